//--- hw/hls_pkg.sv
// Purpose: Shared constants, encodings and state types of the hub lock semaphore.
// Assumes: 32-bit AHB-Lite register access and eight cores sharing one rotating hub slot.
// Notes: Summary of operation is listed below, one line per behaviour.
//
// Summary of operation
// - Release returns lock to free pool.
// - Release zero flag means ID equals zero.
// - Release carry means pool was full before.
// - Release may write ID to the result register.
// - Every operation completes in 7 to 22 cycles.
// - Set forces bit; carry gives prior bit.
// - Set zero flag means ID equals zero.
// - Set writes ID only when asked.
// - Set is instr 000011, source 6.
// - Only lowest 3 destination bits form ID.
// - Clear forces bit zero, source 7, prior bit.
// - Allocate hands out free ID; carry if none.
// - Release is instr 000011, source 5.
package hls_pkg;

    // ------------------------------------------------------------------
    // Register map (byte addresses) and fields
    // ------------------------------------------------------------------
    localparam logic [7:0] HLS_CMD_ADDR = 8'h00;
    localparam logic [7:0] HLS_DEST_ADDR = 8'h04;
    localparam logic [7:0] HLS_STAT_ADDR = 8'h08;
    localparam logic [7:0] HLS_RES_ADDR = 8'h0c;
    localparam logic [7:0] HLS_LOCK_ADDR = 8'h10;

    localparam int HLS_INSTR_LSB = 26;
    localparam int HLS_ZEF_BIT = 25;
    localparam int HLS_CEF_BIT = 24;
    localparam int HLS_REF_BIT = 23;
    localparam int HLS_CORE_LSB = 8;
    localparam int HLS_SRC_LSB = 0;

    localparam logic [5:0] HLS_INSTR_HUB = 6'h03;
    localparam logic [2:0] HLS_SRC_NEW = 3'h4;
    localparam logic [2:0] HLS_SRC_RET = 3'h5;
    localparam logic [2:0] HLS_SRC_SET = 3'h6;
    localparam logic [2:0] HLS_SRC_CLR = 3'h7;

    // ------------------------------------------------------------------
    // Timing: hub access takes a fixed part plus a wait for the slot
    // ------------------------------------------------------------------
    localparam int HLS_HUB_MIN_CYC = 7;
    localparam int HLS_HUB_MAX_CYC = 22;
    localparam int HLS_ROT_CYC = HLS_HUB_MAX_CYC - HLS_HUB_MIN_CYC + 1;
    localparam logic [3:0] HLS_EXEC_CNT = 4'(HLS_HUB_MIN_CYC - 3);
    localparam int HLS_NLOCKS = 8;
    localparam int HLS_IDW = 3;

    typedef enum logic [2:0] {
        HLS_IDLE = 3'b001,
        HLS_WAIT = 3'b010,
        HLS_EXEC = 3'b100
    } hls_phase_t;

    typedef struct packed {
        hls_phase_t phase;
        logic [3:0] slot;
        logic [3:0] cnt;
        logic [2:0] src;
        logic [2:0] core;
        logic zef;
        logic cef;
        logic ref_w;
        logic [31:0] dest;
        logic [31:0] result;
        logic [HLS_NLOCKS-1:0] locks;
        logic [HLS_NLOCKS-1:0] alloc;
        logic zflag;
        logic cflag;
        logic written;
        logic done;
        logic bad;
        logic dsel;
        logic dwrite;
        logic [7:0] daddr;
        logic [31:0] rdata;
    } hls_state_t;

endpackage : hls_pkg

//--- hw/hls_lock_hub.sv
// Purpose: Pool of eight hardware locks with allocate, release, set and clear operations.
// Assumes: Software issues one lock operation at a time through the command register.
// Notes: Zero wait states on the bus; results are read from status and result registers.
//
// Design decisions made here: the AHB-Lite register port and the address map.
`timescale 1ns/1ps

module hls_lock_hub
    import hls_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp
);

    hls_state_t s_r;
    hls_state_t s_nxt;
    logic [HLS_IDW-1:0] id;
    logic [HLS_IDW-1:0] free_id;
    logic any_free;
    logic legal;
    logic cmd_wr;
    logic [31:0] cmd;

    // ------------------------------------------------------------------
    // Lowest free lock search
    // ------------------------------------------------------------------
    always_comb
    begin
        free_id = '0;
        any_free = 1'b0;
        for (int i = HLS_NLOCKS - 1; i >= 0; i--)
        begin
            if (!s_r.alloc[i])
            begin
                free_id = HLS_IDW'(i);
                any_free = 1'b1;
            end
        end
    end

    assign id = s_r.dest[HLS_IDW-1:0];
    assign cmd = hwdata;
    assign cmd_wr = s_r.dsel && s_r.dwrite && (s_r.daddr == HLS_CMD_ADDR);

    assign legal = (cmd[HLS_INSTR_LSB +: 6] == HLS_INSTR_HUB) && cmd[HLS_SRC_LSB + 2];

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb
    begin
        s_nxt = s_r;
        s_nxt.slot = s_r.slot + 4'h1;

        // Address phase capture; writes land in the following data phase.
        if (hready)
        begin
            s_nxt.dsel = hsel && htrans[1];
            s_nxt.dwrite = hwrite;
            s_nxt.daddr = haddr[7:0];
        end

        // Data-phase writes. The command and destination are locked while busy
        // so a running operation cannot have its operands changed under it.
        if (s_r.dsel && s_r.dwrite && s_r.phase == HLS_IDLE)
        begin
            if (s_r.daddr == HLS_DEST_ADDR)
            begin
                s_nxt.dest = hwdata;
            end
            if (cmd_wr)
            begin
                s_nxt.done = 1'b0;
                s_nxt.bad = !legal;
                s_nxt.src = cmd[HLS_SRC_LSB +: 3];
                s_nxt.core = cmd[HLS_CORE_LSB +: 3];
                s_nxt.zef = cmd[HLS_ZEF_BIT];
                s_nxt.cef = cmd[HLS_CEF_BIT];
                s_nxt.ref_w = cmd[HLS_REF_BIT];
                if (legal)
                begin
                    s_nxt.phase = HLS_WAIT;
                end
            end
        end

        unique case (s_r.phase)
            HLS_IDLE:
            begin
            end
            HLS_WAIT:
            begin
                if (s_r.slot == {s_r.core, 1'b0})
                begin
                    s_nxt.phase = HLS_EXEC;
                    s_nxt.cnt = HLS_EXEC_CNT;
                    s_nxt.written = s_r.ref_w;
                    unique case (s_r.src)
                        HLS_SRC_NEW:
                        begin
                            if (any_free)
                            begin
                                s_nxt.alloc[free_id] = 1'b1;
                            end
                            if (s_r.ref_w)
                            begin
                                s_nxt.result = 32'(any_free ? free_id : HLS_IDW'(HLS_NLOCKS - 1));
                            end
                            if (s_r.zef)
                            begin
                                s_nxt.zflag = any_free && (free_id == '0);
                            end
                            if (s_r.cef)
                            begin
                                s_nxt.cflag = !any_free;
                            end
                        end
                        HLS_SRC_RET:
                        begin
                            s_nxt.alloc[id] = 1'b0;
                            if (s_r.cef)
                            begin
                                s_nxt.cflag = &s_r.alloc;
                            end
                        end
                        HLS_SRC_SET:
                        begin
                            s_nxt.locks[id] = 1'b1;
                            if (s_r.cef)
                            begin
                                s_nxt.cflag = s_r.locks[id];
                            end
                        end
                        default:
                        begin
                            s_nxt.locks[id] = 1'b0;
                            if (s_r.cef)
                            begin
                                s_nxt.cflag = s_r.locks[id];
                            end
                        end
                    endcase
                    if (s_r.src != HLS_SRC_NEW)
                    begin
                        if (s_r.zef)
                        begin
                            s_nxt.zflag = (id == '0);
                        end
                        if (s_r.ref_w)
                        begin
                            s_nxt.result = 32'(id);
                        end
                    end
                end
            end
            HLS_EXEC:
            begin
                if (s_r.cnt == 4'h0)
                begin
                    s_nxt.phase = HLS_IDLE;
                    s_nxt.done = 1'b1;
                end
                else
                begin
                    s_nxt.cnt = s_r.cnt - 4'h1;
                end
            end
            default:
            begin
                s_nxt.phase = HLS_IDLE;
            end
        endcase

        // Read data is taken from the updated state, so a read that follows a
        // write back to back already sees the written value.
        s_nxt.rdata = '0;
        if (hready && hsel && htrans[1] && !hwrite)
        begin
            unique case (haddr[7:0])
                HLS_DEST_ADDR: s_nxt.rdata = s_nxt.dest;
                HLS_STAT_ADDR: s_nxt.rdata = {26'h0, s_nxt.bad, s_nxt.written, s_nxt.cflag,
                                              s_nxt.zflag, s_nxt.done, s_nxt.phase != HLS_IDLE};
                HLS_RES_ADDR: s_nxt.rdata = s_nxt.result;
                HLS_LOCK_ADDR: s_nxt.rdata = {16'h0, s_nxt.alloc, s_nxt.locks};
                default: s_nxt.rdata = '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            s_r <= '0;
            s_r.phase <= HLS_IDLE;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [5:0] lat_r;
    always_ff @(posedge clk)
    begin
        if (!rst_n || s_r.phase == HLS_IDLE)
        begin
            lat_r <= 6'h1;
        end
        else
        begin
            lat_r <= lat_r + 6'h1;
        end
    end

    hub_latency_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        $rose(s_r.done) |-> (lat_r >= 6'(HLS_HUB_MIN_CYC) && lat_r <= 6'(HLS_HUB_MAX_CYC)))
        else $error("lock operation latency outside hub window");

    release_frees_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.slot == {s_r.core, 1'b0} && s_r.src == HLS_SRC_RET)
        |=> !s_r.alloc[$past(id)])
        else $error("released lock still allocated");

    release_carry_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.slot == {s_r.core, 1'b0} && s_r.src == HLS_SRC_RET && s_r.cef)
        |=> s_r.cflag == &$past(s_r.alloc))
        else $error("release carry does not match full pool");

    set_prior_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.slot == {s_r.core, 1'b0} && s_r.src == HLS_SRC_SET && s_r.cef)
        |=> s_r.cflag == $past(s_r.locks[id]) && s_r.locks[$past(id)])
        else $error("set did not return prior state or set the bit");

    clear_low_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.slot == {s_r.core, 1'b0} && s_r.src == HLS_SRC_CLR)
        |=> !s_r.locks[$past(id)])
        else $error("clear left the lock bit set");

    zero_flag_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.slot == {s_r.core, 1'b0} && s_r.zef && s_r.src != HLS_SRC_NEW)
        |=> s_r.zflag == ($past(id) == '0))
        else $error("zero flag does not match lock ID");

    no_store_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && !s_r.ref_w) |=> $stable(s_r.result))
        else $error("result changed without store effect");

    alloc_unique_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.slot == {s_r.core, 1'b0} && s_r.src == HLS_SRC_NEW && any_free)
        |=> s_r.alloc == ($past(s_r.alloc) | (8'h01 << $past(free_id))))
        else $error("allocate did not claim exactly the lowest free lock");

    release_keeps_a:
    assert property (@(posedge clk) disable iff (!rst_n)
        (s_r.phase == HLS_WAIT && s_r.src == HLS_SRC_RET) |=> $stable(s_r.locks))
        else $error("release changed a lock bit");

endmodule : hls_lock_hub

//--- bench/hls_core_bfm.sv
// Purpose: Processor-core model that issues lock operations over AHB-Lite.
// Assumes: One slave whose hreadyout is the bus hready; single word transfers only.
// Notes: Every wait is bounded; a hung bus ends the run through the bench.
`timescale 1ns/1ps

module hls_core_bfm
    import hls_pkg::*;
(
    input wire logic clk,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata
);
    initial
    begin
        hsel = 1'b1;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
    end

    // ------------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------------
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (hready !== 1'b1 && n < 16);
        if (hready !== 1'b1)
        begin
            tb.bad_count++;
            tb.finish_test();
        end
    endtask : wait_ready

    task automatic bus_write(input logic [31:0] addr, input logic [31:0] data);
        haddr <= addr;
        hwrite <= 1'b1;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        hwdata <= data;
        wait_ready();
    endtask : bus_write

    task automatic bus_read(input logic [31:0] addr, output logic [31:0] data);
        haddr <= addr;
        hwrite <= 1'b0;
        htrans <= 2'b10;
        wait_ready();
        htrans <= 2'b00;
        wait_ready();
        data = hrdata;
    endtask : bus_read

    task automatic issue(input logic [5:0] instr, input logic [2:0] src, input logic [2:0] fx,
        input logic [2:0] core, input logic [31:0] dest);
        bus_write({24'h0, HLS_DEST_ADDR}, dest);
        bus_write({24'h0, HLS_CMD_ADDR}, {instr, fx, 12'h0, core, 5'h0, src});
    endtask : issue
endmodule : hls_core_bfm

//--- bench/tb.sv
// Purpose: Self-checking bench for the hub lock semaphore.
// Assumes: Core model on the register bus; status is polled until done.
// Notes: Allocation takes the lowest free ID; a reused ID is checked against the freed set.
`timescale 1ns/1ps

module tb
    import hls_pkg::*;
;
    logic clk;
    logic rst_n;
    logic hsel;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic hwrite;
    logic [2:0] hsize;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [31:0] d;
    logic [31:0] lk;

    initial clk = 1'b0;
    always #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    hls_lock_hub uut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
    hls_core_bfm core (.clk(clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

    // ------------------------------------------------------------------
    // Shared checks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] v;
        core.bus_read({24'h0, a}, v);
        chk(v, exp);
    endtask : rd_chk

    // Expected flags are {written, carry, zero}; done must follow within the hub window.
    task automatic op(input logic [2:0] src, input logic [2:0] fx, input logic [2:0] cid,
        input logic [31:0] dest, input logic [2:0] exp);
        int t0;
        int n;
        logic [31:0] s;
        core.issue(HLS_INSTR_HUB, src, fx, cid, dest);
        t0 = cyc;
        n = 0;
        s = 32'h0;
        while (s[1] !== 1'b1 && n < 20)
        begin
            core.bus_read({24'h0, HLS_STAT_ADDR}, s);
            n++;
        end
        if (s[1] !== 1'b1)
        begin
            bad_count++;
            finish_test();
        end
        chk({31'h0, (cyc - t0 >= HLS_HUB_MIN_CYC) && (cyc - t0 <= HLS_HUB_MAX_CYC)}, 32'h1);
        chk({26'h0, s[5:0]}, {26'h0, 1'b0, exp, 2'b10});
    endtask : op

    task automatic finish_test();
        $display("TB: compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        rd_chk(HLS_LOCK_ADDR, 32'h0);
        rd_chk(HLS_STAT_ADDR, 32'h0);
        core.bus_write(32'h14, 32'hffff_ffff);
        rd_chk(8'h14, 32'h0);
        rd_chk(HLS_CMD_ADDR, 32'h0);
        chk({31'h0, hresp}, 32'h0);
        chk({31'h0, hreadyout}, 32'h1);
        $display("TB: test reset done");
    endtask : t_reset

    task automatic t_alloc();
        for (int i = 0; i < 8; i++)
        begin
            op(HLS_SRC_NEW, 3'b111, 3'(i), 32'h0, {2'b10, i == 0});
            rd_chk(HLS_RES_ADDR, 32'(i));
        end
        rd_chk(HLS_LOCK_ADDR, 32'h0000_ff00);
        op(HLS_SRC_NEW, 3'b111, 3'h7, 32'h0, 3'b110);
        rd_chk(HLS_RES_ADDR, 32'h7);
        $display("TB: test alloc done");
    endtask : t_alloc

    task automatic t_release();
        op(HLS_SRC_RET, 3'b111, 3'h3, 32'h8, 3'b111);
        rd_chk(HLS_RES_ADDR, 32'h0);
        op(HLS_SRC_RET, 3'b110, 3'h1, 32'h5, 3'b000);
        rd_chk(HLS_RES_ADDR, 32'h0);
        rd_chk(HLS_LOCK_ADDR, 32'h0000_de00);
        op(HLS_SRC_NEW, 3'b011, 3'h2, 32'h0, 3'b100);
        core.bus_read({24'h0, HLS_RES_ADDR}, d);
        chk({31'h0, d === 32'h0 || d === 32'h5}, 32'h1);
        lk = 32'h0000_de00 | (32'h100 << d[2:0]);
        rd_chk(HLS_LOCK_ADDR, lk);
        $display("TB: test release done");
    endtask : t_release

    task automatic t_setclr();
        op(HLS_SRC_SET, 3'b110, 3'h2, 32'hd, 3'b000);
        rd_chk(HLS_RES_ADDR, d);
        op(HLS_SRC_SET, 3'b111, 3'h4, 32'h5, 3'b110);
        rd_chk(HLS_RES_ADDR, 32'h5);
        op(HLS_SRC_SET, 3'b111, 3'h6, 32'h8, 3'b101);
        rd_chk(HLS_RES_ADDR, 32'h0);
        rd_chk(HLS_LOCK_ADDR, lk | 32'h21);
        op(HLS_SRC_CLR, 3'b000, 3'h7, 32'h0, 3'b001);
        op(HLS_SRC_CLR, 3'b010, 3'h0, 32'h5, 3'b011);
        op(HLS_SRC_CLR, 3'b111, 3'h1, 32'h5, 3'b100);
        rd_chk(HLS_RES_ADDR, 32'h5);
        op(HLS_SRC_SET, 3'b000, 3'h5, 32'h7, 3'b000);
        op(HLS_SRC_RET, 3'b000, 3'h3, 32'h7, 3'b000);
        lk = (lk & ~32'h8000) | 32'h80;
        rd_chk(HLS_LOCK_ADDR, lk);
        $display("TB: test set clear done");
    endtask : t_setclr

    task automatic t_bad();
        core.issue(6'h04, HLS_SRC_SET, 3'b111, 3'h0, 32'h1);
        core.bus_read({24'h0, HLS_STAT_ADDR}, d);
        chk(d & 32'h23, 32'h20);
        core.issue(HLS_INSTR_HUB, 3'h3, 3'b111, 3'h0, 32'h1);
        core.bus_read({24'h0, HLS_STAT_ADDR}, d);
        chk(d & 32'h23, 32'h20);
        rd_chk(HLS_LOCK_ADDR, lk);
        $display("TB: test bad command done");
    endtask : t_bad

    initial
    begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_alloc();
        t_release();
        t_setclr();
        t_bad();
        finish_test();
    end
endmodule : tb
